// File: logic/opcode_decoder.sv
// Instruction word decoder for the stack processor
`timescale 1ns/10ps
`include "opdec_regs.svh"
module opcode_decoder (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                resetn_i,
   // Instruction and machine state
   input  wire logic                instr_valid_i,
   input  wire logic [15:0]         instr_i,
   input  wire logic [15:0]         top_i,
   input  wire logic [15:0]         pc_i,
   input  wire logic [15:0]         code_page_reg_i,
   // Decoded control
   output opdec_pkg::dec_out_t      dec_o,
   output logic                     software_irq_flag_o,
   output logic [15:0]              index_o
);
   import opdec_pkg::*;

   dec_state_t st;
   dec_state_t next_st;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   always_comb begin
      logic [3:0] grp;
      logic [4:0] ga;
      logic       r;
      logic       wr;
      grp = instr_i[15:12];
      ga  = instr_i[4:0];
      r   = instr_i[`POS_RET];
      wr  = instr_i[7];
      next_st = st;
      next_st.dec = '0;
      next_st.dec.next_index = st.index;
      if (instr_valid_i) begin
         next_st.dec.valid = 1'b1;
         if (!instr_i[15]) begin
            next_st.dec.op = OP_CALL;
            next_st.dec.push_rs = 1'b1;
            next_st.dec.target = {instr_i[14:0], 1'b0};
         end else begin
            next_st.dec.ret = r;
            next_st.dec.inv = instr_i[`POS_INV]
               && (instr_i[11:9] == 3'h0 || instr_i[11:9] == 3'h7);
            case (grp)
               `GRP_BR_ZERO, `GRP_BR_MISC: begin
                  next_st.dec.ret = 1'b0;
                  next_st.dec.inv = 1'b0;
                  next_st.dec.target = {3'h0, instr_i[12:0]};
                  next_st.dec.target[12] = 1'b0;
                  if (grp == `GRP_BR_ZERO) begin
                     next_st.dec.op = OP_BRANCH;
                     next_st.dec.take_branch = (top_i == 16'h0000);
                     next_st.dec.pop_ps = !instr_i[`POS_BR_MODE];
                  end else if (!instr_i[`POS_BR_MODE]) begin
                     next_st.dec.op = OP_BRANCH;
                     next_st.dec.take_branch = 1'b1;
                  end else begin
                     next_st.dec.op = OP_BR_DEC;
                     next_st.dec.take_branch = (st.index != 16'h0000);
                     next_st.dec.idx_pop = (st.index == 16'h0000);
                     next_st.dec.next_index = st.index - 16'h0001;
                  end
               end
               `GRP_BUS: begin
                  if (instr_i[6]) begin
                     next_st.dec.op = OP_LIT;
                     next_st.dec.push_ps = 1'b1;
                     next_st.dec.operand = {11'h000, instr_i[4:0]};
                  end else if (instr_i[11:8] == 4'h0 && instr_i[4:0] == {1'b1, `NIB_SOFT}) begin
                     next_st.dec.op = OP_SOFT;
                     if (instr_i[3:0] == `NIB_SOFT) begin
                        next_st.soft_irq = wr;
                     end
                  end else if (instr_i[11:8] == 4'h0 && instr_i[4:0] == {1'b0, `NIB_PAGE}) begin
                     next_st.dec.op = OP_PAGE;
                     next_st.dec.sel_data_page = wr;
                     next_st.dec.sel_code_page = !wr;
                  end else begin
                     next_st.dec.op = wr ? OP_BUS_WR : OP_BUS_RD;
                     next_st.dec.bus_addr = ga;
                     // Bus space reaches on-chip registers too
                     if (!wr) begin
                        case (ga)
                           `BUS_IDX: begin
                              next_st.dec.push_ps = 1'b1;
                              next_st.dec.operand = r ? top_i : st.index;
                           end
                           `BUS_IDX_POP: begin
                              next_st.dec.push_ps = 1'b1;
                              next_st.dec.operand = r ? top_i : st.index;
                              next_st.dec.pop_rs = !r;
                           end
                           `BUS_IDX_SHL: begin
                              next_st.dec.push_ps = 1'b1;
                              next_st.dec.operand = {st.index[14:0], 1'b0};
                           end
                           `BUS_PC: begin
                              next_st.dec.push_ps = 1'b1;
                              next_st.dec.operand = pc_i;
                           end
                           default: ;
                        endcase
                     end else begin
                        case (ga)
                           `BUS_IDX, `BUS_IDX_POP, `BUS_IDX_SHL: begin
                              next_st.dec.idx_load = 1'b1;
                              next_st.dec.next_index = top_i;
                              next_st.dec.ret_first = r;
                              next_st.dec.pop_ps = (ga != `BUS_IDX) || r;
                              next_st.dec.stream = (ga == `BUS_IDX_SHL);
                           end
                           `BUS_PC: begin
                              next_st.dec.pop_ps = 1'b1;
                              next_st.dec.push_rs = 1'b1;
                              if (!r) begin
                                 next_st.dec.op = OP_CALL;
                                 next_st.dec.target = top_i;
                              end
                           end
                           default: ;
                        endcase
                     end
                  end
               end
               `GRP_USER: begin
                  next_st.dec.op = OP_USER;
                  next_st.dec.user_addr = instr_i[4:0];
               end
               `GRP_ALU: next_st.dec.op = OP_ALU;
               `GRP_LONG: next_st.dec.op = OP_LONG;
               4'he, 4'hf: next_st.dec.op = OP_MEM;
               default: next_st.dec.op = OP_NONE;
            endcase
         end
      end
      next_st.index = next_st.dec.next_index;
      if (!resetn_i) begin
         next_st = '0;
         next_st.index = `RESET_WORD;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign dec_o               = st.dec;
   assign software_irq_flag_o = st.soft_irq;
   assign index_o             = st.index;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_lit;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[6])
         |=> (dec_o.op == OP_LIT && dec_o.operand == {11'h000, $past(instr_i[4:0])});
   endproperty
   a_lit: assert property (p_lit) else $error("short literal wrong");

   property p_call;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && !instr_i[15])
         |=> (dec_o.op == OP_CALL && dec_o.target == {$past(instr_i[14:0]), 1'b0});
   endproperty
   a_call: assert property (p_call) else $error("call target wrong");

   property p_ret_br;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:13] == 3'h4) |=> !dec_o.ret;
   endproperty
   a_ret_br: assert property (p_ret_br) else $error("return on branch");

   property p_ret_bit;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:13] != 3'h4 && instr_i[15]) |=> dec_o.ret == $past(instr_i[5]);
   endproperty
   a_ret_bit: assert property (p_ret_bit) else $error("return bit lost");

   property p_brz;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BR_ZERO)
         |=> dec_o.take_branch == ($past(top_i) == 16'h0000);
   endproperty
   a_brz: assert property (p_brz) else $error("zero branch wrong");

   property p_dec;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:11] == 5'h13 && index_o != 16'h0000)
         |=> (dec_o.take_branch && index_o == $past(index_o) - 16'h0001);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement branch wrong");

   property p_wr_idx;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h04
         && instr_i[4:0] == `BUS_IDX) |=> (index_o == $past(top_i) && !dec_o.pop_ps);
   endproperty
   a_wr_idx: assert property (p_wr_idx) else $error("index write wrong");

   property p_soft;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:8] == 8'hb0 && instr_i[6] == 1'b0 && instr_i[4:0] == 5'h10)
         |=> software_irq_flag_o == $past(instr_i[7]);
   endproperty
   a_soft: assert property (p_soft) else $error("soft irq flag wrong");

   property p_rd_pc;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:6] == 6'h00
         && instr_i[4:0] == `BUS_PC) |=> dec_o.operand == $past(pc_i);
   endproperty
   a_rd_pc: assert property (p_rd_pc) else $error("pc read wrong");

   property p_user;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_USER)
         |=> (dec_o.op == OP_USER && dec_o.user_addr == $past(instr_i[4:0]));
   endproperty
   a_user: assert property (p_user) else $error("user address wrong");

   property p_bus_addr;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && !instr_i[6] && instr_i[11:8] != 4'h0)
         |=> dec_o.bus_addr == $past(instr_i[4:0]);
   endproperty
   a_bus_addr: assert property (p_bus_addr) else $error("bus address wrong");

   property p_rd_idx;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h00
         && instr_i[4:0] == `BUS_IDX) |=> (dec_o.operand == $past(index_o) && !dec_o.pop_rs);
   endproperty
   a_rd_idx: assert property (p_rd_idx) else $error("index read wrong");

   property p_rd_pop;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h00
         && instr_i[4:0] == `BUS_IDX_POP) |=> (dec_o.operand == $past(index_o) && dec_o.pop_rs);
   endproperty
   a_rd_pop: assert property (p_rd_pop) else $error("popping read wrong");

   property p_rd_top;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h01
         && instr_i[4:0] == `BUS_IDX_POP)
         |=> (dec_o.operand == $past(top_i) && !dec_o.pop_rs && dec_o.ret);
   endproperty
   a_rd_top: assert property (p_rd_top) else $error("top read wrong");

   property p_rd_shl;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:6] == 6'h00
         && instr_i[4:0] == `BUS_IDX_SHL)
         |=> (dec_o.operand == {$past(index_o[14:0]), 1'b0} && !dec_o.pop_rs);
   endproperty
   a_rd_shl: assert property (p_rd_shl) else $error("shifted read wrong");

   property p_stream;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h04
         && instr_i[4:0] == `BUS_IDX_SHL)
         |=> (dec_o.stream && dec_o.pop_ps && index_o == $past(top_i));
   endproperty
   a_stream: assert property (p_stream) else $error("stream count wrong");

   property p_wr_call;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h04
         && instr_i[4:0] == `BUS_PC)
         |=> (dec_o.op == OP_CALL && dec_o.target == $past(top_i) && dec_o.pop_ps);
   endproperty
   a_wr_call: assert property (p_wr_call) else $error("indirect call wrong");

   property p_wr_ret;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h05
         && instr_i[4:0] == `BUS_PC) |=> (dec_o.push_rs && dec_o.ret && dec_o.pop_ps);
   endproperty
   a_wr_ret: assert property (p_wr_ret) else $error("push and return wrong");

   property p_ret_first;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[11:5] == 7'h05
         && (instr_i[4:0] == `BUS_IDX || instr_i[4:0] == `BUS_IDX_POP))
         |=> (dec_o.ret_first && dec_o.idx_load && index_o == $past(top_i));
   endproperty
   a_ret_first: assert property (p_ret_first) else $error("return first wrong");

   property p_page;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:8] == 8'hb0 && !instr_i[6] && instr_i[4:0] == 5'h0d)
         |=> (dec_o.op == OP_PAGE && dec_o.sel_data_page == $past(instr_i[7])
              && dec_o.sel_code_page == !$past(instr_i[7]));
   endproperty
   a_page: assert property (p_page) else $error("page select wrong");

   property p_inv;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15] && instr_i[15:13] != 3'h4 && instr_i[11:9] == 3'h0)
         |=> dec_o.inv == $past(instr_i[`POS_INV]);
   endproperty
   a_inv: assert property (p_inv) else $error("invert bit wrong");

   property p_unlisted;
      @(posedge clk_i) disable iff (!resetn_i)
      (instr_valid_i && instr_i[15:12] == `GRP_BUS && instr_i[7:6] == 2'b10
         && instr_i[4:3] != 2'b00)
         |=> (!dec_o.idx_load && !dec_o.push_rs && index_o == $past(index_o));
   endproperty
   a_unlisted: assert property (p_unlisted) else $error("unlisted write acted");

   property p_valid;
      @(posedge clk_i) disable iff (!resetn_i)
      1'b1 |=> dec_o.valid == $past(instr_valid_i);
   endproperty
   a_valid: assert property (p_valid) else $error("decode valid wrong");

   property p_flag_hold;
      @(posedge clk_i) disable iff (!resetn_i)
      !(instr_valid_i && instr_i[15:8] == 8'hb0 && !instr_i[6] && instr_i[4:0] == 5'h10)
         |=> $stable(software_irq_flag_o);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("soft flag moved");
endmodule

// File: logic/opdec_regs.svh
// Constants of the stack processor instruction decoder
`ifndef OPDEC_REGS_SVH
`define OPDEC_REGS_SVH
`define BUS_IDX      5'h00
`define BUS_IDX_POP  5'h01
`define BUS_IDX_SHL  5'h02
`define BUS_PC       5'h07
`define GRP_BR_ZERO  4'h8
`define GRP_BR_MISC  4'h9
`define GRP_ALU      4'ha
`define GRP_BUS      4'hb
`define GRP_USER     4'hc
`define GRP_LONG     4'hd
`define POS_RET      5
`define POS_INV      8
`define POS_BR_MODE  11
`define NIB_PAGE     4'hd
`define NIB_SOFT     4'h0
`define RESET_WORD   16'h0000
`endif

// File: logic/opdec_pkg.sv
// Types of the stack processor instruction decoder
package opdec_pkg;
   typedef enum logic [3:0] {
      OP_NONE, OP_CALL, OP_BRANCH, OP_BR_DEC, OP_LIT, OP_BUS_RD, OP_BUS_WR,
      OP_USER, OP_ALU, OP_LONG, OP_MEM, OP_PAGE, OP_SOFT
   } op_class_t;
   typedef struct packed {
      logic        valid;
      op_class_t   op;
      logic        ret;
      logic        inv;
      logic        push_ps;
      logic        pop_ps;
      logic        pop_rs;
      logic        push_rs;
      logic        ret_first;
      logic        idx_load;
      logic        idx_pop;
      logic        stream;
      logic        take_branch;
      logic        sel_data_page;
      logic        sel_code_page;
      logic [15:0] operand;
      logic [4:0]  bus_addr;
      logic [4:0]  user_addr;
      logic [15:0] target;
      logic [15:0] next_index;
   } dec_out_t;
   typedef struct packed {
      dec_out_t    dec;
      logic        soft_irq;
      logic [15:0] index;
   } dec_state_t;
endpackage

// File: sim/tb.sv
// Self-checking testbench for the stack processor instruction decoder
`timescale 1ns/10ps
module tb;
   import opdec_pkg::*;
   logic        clk_i           = 1'b0;
   logic        resetn_i        = 1'b0;
   logic        instr_valid_i   = 1'b0;
   logic [15:0] instr_i         = 16'h0000;
   logic [15:0] top_i           = 16'h0000;
   logic [15:0] pc_i            = 16'h0456;
   logic [15:0] code_page_reg_i = 16'h0003;
   dec_out_t    dec_o;
   logic        software_irq_flag_o;
   logic [15:0] index_o;
   int          error_cnt       = 0;
   int          compares        = 0;
   int          cycles          = 0;

   always #5 clk_i = ~clk_i;

   opcode_decoder opcode_decoder_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .top_i(top_i), .pc_i(pc_i), .code_page_reg_i(code_page_reg_i),
      .dec_o(dec_o), .software_irq_flag_o(software_irq_flag_o), .index_o(index_o));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
      end
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // One word in, decode sampled after the answering edge
   task automatic issue(input logic [15:0] word, input logic [15:0] top);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i       <= word;
      top_i         <= top;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask

   task automatic end_sim();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_literal();
      issue(16'hbe40, 16'hffff);
      chk_word(16'(dec_o.op), 16'(OP_LIT), "literal op");
      chk_word(dec_o.operand, 16'h0000, "literal 0");
      issue(16'hbe5f, 16'h0000);
      chk_word(dec_o.operand, 16'h001f, "literal 31");
      $display("test literal done");
   endtask

   task automatic t_index();
      issue(16'hb080, 16'h1234);
      chk_word(index_o, 16'h1234, "write 0 index");
      chk_bit(dec_o.idx_load, 1'b1, "write 0 load");
      chk_bit(dec_o.push_rs, 1'b0, "write 0 no rs push");
      chk_word(16'(dec_o.bus_addr), 16'h0000, "bus addr");
      issue(16'hb000, 16'h0000);
      chk_word(16'(dec_o.op), 16'(OP_BUS_RD), "read op");
      chk_word(dec_o.operand, 16'h1234, "read 0 value");
      chk_bit(dec_o.pop_rs, 1'b0, "read 0 no rs pop");
      issue(16'hb001, 16'h0000);
      chk_bit(dec_o.pop_rs, 1'b1, "read 1 rs pop");
      chk_word(dec_o.operand, 16'h1234, "read 1 value");
      issue(16'hb021, 16'h0c0c);
      chk_word(dec_o.operand, 16'h0c0c, "read 1 ret top");
      chk_bit(dec_o.pop_rs, 1'b0, "read 1 ret no pop");
      chk_bit(dec_o.ret, 1'b1, "read 1 ret");
      issue(16'hb0a1, 16'h5a5a);
      chk_bit(dec_o.ret_first, 1'b1, "write ret first");
      chk_word(index_o, 16'h5a5a, "write ret index");
      $display("test index done");
   endtask

   task automatic t_stream_pc();
      issue(16'hb022, 16'h0000);
      chk_bit(dec_o.pop_rs, 1'b0, "shift read no pop");
      chk_bit(dec_o.ret, 1'b1, "shift read ret");
      chk_word(dec_o.operand, 16'hb4b4, "shift read value");
      issue(16'hb082, 16'h0007);
      chk_bit(dec_o.stream, 1'b1, "stream flag");
      chk_bit(dec_o.pop_ps, 1'b1, "stream pop");
      chk_word(index_o, 16'h0007, "stream count");
      issue(16'hb027, 16'h0000);
      chk_bit(dec_o.push_ps, 1'b1, "pc read push");
      chk_bit(dec_o.ret, 1'b1, "pc read ret");
      chk_word(dec_o.operand, 16'h0456, "pc read value");
      issue(16'hb087, 16'h0abc);
      chk_bit(dec_o.pop_ps, 1'b1, "pc write pop");
      chk_bit(dec_o.ret, 1'b0, "pc write no ret");
      chk_word(16'(dec_o.op), 16'(OP_CALL), "pc write call");
      chk_word(dec_o.target, 16'h0abc, "pc write target");
      issue(16'hb0a7, 16'h0abc);
      chk_bit(dec_o.push_rs, 1'b1, "pc write rs push");
      $display("test stream and pc done");
   endtask

   task automatic t_call_branch();
      issue(16'h1234, 16'h0000);
      chk_word(16'(dec_o.op), 16'(OP_CALL), "call op");
      chk_word(dec_o.target, 16'h2468, "call target");
      chk_bit(dec_o.ret, 1'b0, "call no ret");
      issue(16'h9123, 16'h0005);
      chk_bit(dec_o.take_branch, 1'b1, "uncond");
      chk_bit(dec_o.ret, 1'b0, "branch no ret");
      issue(16'h8010, 16'h0000);
      chk_bit(dec_o.take_branch, 1'b1, "zero branch");
      chk_bit(dec_o.pop_ps, 1'b1, "zero branch pop");
      issue(16'h8810, 16'h0001);
      chk_bit(dec_o.take_branch, 1'b0, "nonzero hold");
      chk_bit(dec_o.pop_ps, 1'b0, "keep branch no pop");
      issue(16'hb080, 16'h0002);
      issue(16'h9800, 16'h0000);
      chk_bit(dec_o.take_branch, 1'b1, "dec branch");
      chk_word(index_o, 16'h0001, "dec index");
      issue(16'hb080, 16'h0000);
      issue(16'h9800, 16'h0000);
      chk_bit(dec_o.take_branch, 1'b0, "dec fall");
      chk_bit(dec_o.idx_pop, 1'b1, "dec pop index");
      $display("test call and branch done");
   endtask

   task automatic t_misc();
      issue(16'hb08d, 16'h0000);
      chk_bit(dec_o.sel_data_page, 1'b1, "data page");
      issue(16'hb00d, 16'h0000);
      chk_bit(dec_o.sel_code_page, 1'b1, "code page");
      issue(16'hb0b0, 16'h0000);
      chk_bit(software_irq_flag_o, 1'b1, "soft set");
      chk_bit(dec_o.ret, 1'b1, "soft ret");
      issue(16'hb010, 16'h0000);
      chk_bit(software_irq_flag_o, 1'b0, "soft clear");
      issue(16'ha100, 16'h0000);
      chk_bit(dec_o.inv, 1'b1, "invert");
      chk_bit(dec_o.ret, 1'b0, "alu no ret");
      issue(16'ha300, 16'h0000);
      chk_bit(dec_o.inv, 1'b0, "alu code no invert");
      issue(16'hb011, 16'h0000);
      chk_word(16'(dec_o.bus_addr), 16'h0011, "high bus addr");
      chk_bit(software_irq_flag_o, 1'b0, "high bus no soft");
      issue(16'hc03f, 16'h0000);
      chk_word(16'(dec_o.user_addr), 16'h001f, "user");
      issue(16'hb080, 16'h1357);
      issue(16'hb023, 16'h9999);
      chk_bit(dec_o.idx_load, 1'b0, "unlisted no load");
      chk_word(index_o, 16'h1357, "unlisted index");
      issue(16'hb0a3, 16'h9999);
      chk_bit(dec_o.idx_load, 1'b0, "unlisted write no load");
      chk_word(index_o, 16'h1357, "unlisted write index");
      $display("test page soft invert done");
   endtask

   task automatic t_reset_mid();
      issue(16'hb0b0, 16'h0000);
      issue(16'hb080, 16'h4321);
      @(posedge clk_i);
      resetn_i <= 1'b0;
      @(posedge clk_i);
      resetn_i <= 1'b1;
      #1;
      chk_bit(software_irq_flag_o, 1'b0, "mid reset flag");
      chk_word(index_o, 16'h0000, "mid reset index");
      chk_bit(dec_o.valid, 1'b0, "mid reset decode");
      issue(16'hbe45, 16'h0000);
      chk_word(dec_o.operand, 16'h0005, "literal after reset");
      $display("test mid reset done");
   endtask

   // ---------------------------------------------------------------
   // Main sequence and timeout
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         $display("wrong value at %0t: timeout", $time);
         end_sim();
      end
   end

   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      #1;
      chk_bit(dec_o === '0, 1'b1, "reset decode");
      chk_word(index_o, 16'h0000, "reset index");
      chk_bit(software_irq_flag_o, 1'b0, "reset flag");
      $display("test reset done");
      t_literal();
      t_index();
      t_stream_pc();
      t_call_branch();
      t_misc();
      t_reset_mid();
      end_sim();
   end
endmodule
